// *** bench/osc_model.sv ***
// far-side model: crystal oscillator and watchdog rc oscillator
`timescale 1ns/1ns
module osc_model
(
    input wire logic i_clk,
    input wire logic i_osc_run,
    output logic o_osc_tick,
    output logic o_rc_tick
);
    logic [2:0] osc_cnt_q; // crystal phase, period seven cycles
    logic [3:0] rc_cnt_q; // rc phase, period ten cycles
    initial
    begin
        osc_cnt_q = 3'h0;
        rc_cnt_q = 4'h0;
        o_osc_tick = 1'h0;
        o_rc_tick = 1'h0;
    end
    // crystal stands still while stopped for sleep
    always @(posedge i_clk)
    begin
        if (i_osc_run === 1'h1)
        begin
            osc_cnt_q <= (osc_cnt_q == 3'h6) ? 3'h0 : osc_cnt_q + 3'h1;
            o_osc_tick <= osc_cnt_q[2];
        end
    end
    // rc oscillator runs free, whatever the crystal does
    always @(posedge i_clk)
    begin
        rc_cnt_q <= (rc_cnt_q == 4'h9) ? 4'h0 : rc_cnt_q + 4'h1;
        o_rc_tick <= (rc_cnt_q < 4'h5);
    end
endmodule // osc_model

// *** bench/reset_and_power_mode_control_tb.sv ***
// self-checking bench for the reset and power-mode sequencer
`timescale 1ns/1ns
module reset_and_power_mode_control_tb;
    localparam int PWRUP_N = 8000; // power-up hold, longer than start-up
    localparam int OST_CYC = 7168; // 1024 crystal ticks of seven cycles
    logic i_clk = 1'h0;
    logic i_srst = 1'h1;
    logic i_power_on = 1'h0;
    logic i_brown_out_reset = 1'h0;
    logic i_ext_reset_n = 1'h1;
    logic i_irq_pending = 1'h0;
    logic i_osc_tick; // from oscillator model
    logic i_rc_tick; // from oscillator model
    rst_pwr_pkg::cfg_t i_cfg = '0;
    rst_pwr_pkg::cpu_req_t i_cpu_req = '0;
    logic o_core_reset, o_cpu_clk_en, o_osc_run, o_periph_clk_en;
    logic o_watchdog_timer_on, o_watchdog_timer_wake;
    logic [2:0] o_clk_source;
    logic [2:0] src; // expected clock source
    logic [31:0] seed = 32'h437292BC; // random state
    int error_cnt = 0;
    int n_checks = 0;
    int wake_cnt = 0; // watchdog wake pulses seen
    int n, k;
    always #10 i_clk = ~i_clk;
    reset_and_power_mode_control #(.PWRUP_COUNT(PWRUP_N)) i_dut
    (
        .i_clk(i_clk), .i_srst(i_srst), .i_power_on(i_power_on),
        .i_brown_out_reset(i_brown_out_reset),
        .i_ext_reset_n(i_ext_reset_n), .i_osc_tick(i_osc_tick),
        .i_rc_tick(i_rc_tick), .i_irq_pending(i_irq_pending),
        .i_cfg(i_cfg), .i_cpu_req(i_cpu_req),
        .o_core_reset(o_core_reset), .o_cpu_clk_en(o_cpu_clk_en),
        .o_osc_run(o_osc_run), .o_periph_clk_en(o_periph_clk_en),
        .o_watchdog_timer_on(o_watchdog_timer_on),
        .o_watchdog_timer_wake(o_watchdog_timer_wake),
        .o_clk_source(o_clk_source)
    );
    osc_model i_osc
    (
        .i_clk(i_clk), .i_osc_run(o_osc_run),
        .o_osc_tick(i_osc_tick), .o_rc_tick(i_rc_tick)
    );
    // count one-cycle wake pulses
    always @(posedge i_clk)
    begin
        if (o_watchdog_timer_wake === 1'h1)
            wake_cnt++;
    end
    // next random state
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // compare a design value
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // compare a measured length against a window
    task automatic chk_rng(string nm, int lo, int hi, int v);
        n_checks++;
        if (v < lo || v > hi)
        begin
            error_cnt++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask
    // wait for reset hold to start, then measure it in cycles
    task automatic wait_hold(output int len);
        int w;
        w = 0;
        len = 0;
        while (o_core_reset !== 1'h1 && w < 4000)
        begin
            @(negedge i_clk);
            w++;
        end
        while (o_core_reset !== 1'h0 && len < 20000)
        begin
            @(negedge i_clk);
            len++;
        end
    endtask
    // counts, verdict, end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, well beyond the expected run
    initial
    begin
        #(20 * 90000);
        error_cnt++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_srst <= 1'h0;
        // plain reset: start-up timer alone holds
        wait_hold(n);
        chk_rng("ost hold", OST_CYC - 8, OST_CYC + 40, n);
        chk("cpu clk run", 8'h1, o_cpu_clk_en);
        $display("test reset done");
        // power-on: both timers, config sampled
        seed = lfsr(seed);
        src = seed[2:0];
        @(posedge i_clk);
        i_cfg.clk_source <= src;
        i_power_on <= 1'h1;
        repeat (8) @(posedge i_clk);
        i_power_on <= 1'h0;
        wait_hold(n);
        chk_rng("por hold", PWRUP_N - 10, PWRUP_N + 40, n);
        chk("por source", src, o_clk_source);
        // software switch honoured, new config waits for bor
        seed = lfsr(seed);
        @(posedge i_clk);
        i_cfg.clk_source <= ~src;
        i_cpu_req.clk_target <= seed[5:3];
        i_cpu_req.clk_switch <= 1'h1;
        @(posedge i_clk);
        i_cpu_req.clk_switch <= 1'h0;
        repeat (3) @(negedge i_clk);
        chk("sw source", seed[5:3], o_clk_source);
        $display("test power-on done");
        // brown-out: no power-up hold
        @(posedge i_clk);
        i_brown_out_reset <= 1'h1;
        repeat (8) @(posedge i_clk);
        i_brown_out_reset <= 1'h0;
        wait_hold(n);
        chk_rng("bor hold", OST_CYC - 16, OST_CYC + 40, n);
        chk("bor source", 3'(~src), o_clk_source);
        $display("test brown-out done");
        // watchdog enable: config forces, else software
        for (k = 0; k < 4; k++)
        begin
            @(posedge i_clk);
            i_cfg.wdog_always_on <= k[1];
            i_cpu_req.wdog_sw_enable <= k[0];
            @(negedge i_clk);
            chk("wdog on", k[1] | k[0], o_watchdog_timer_on);
        end
        // watchdog off again, so it cannot reset the later tests
        @(posedge i_clk);
        i_cfg.wdog_always_on <= 1'h0;
        i_cpu_req.wdog_sw_enable <= 1'h0;
        // idle stops cpu only, interrupt resumes
        @(posedge i_clk);
        i_cpu_req.enter_idle <= 1'h1;
        @(posedge i_clk);
        i_cpu_req.enter_idle <= 1'h0;
        repeat (2) @(negedge i_clk);
        chk("idle cpu", 8'h0, o_cpu_clk_en);
        chk("idle periph", 8'h1, o_periph_clk_en);
        chk("idle osc", 8'h1, o_osc_run);
        @(posedge i_clk);
        i_irq_pending <= 1'h1;
        @(posedge i_clk);
        i_irq_pending <= 1'h0;
        repeat (2) @(negedge i_clk);
        chk("idle exit", 8'h1, o_cpu_clk_en);
        $display("test idle done");
        // sleep woken by interrupt, external reset, watchdog
        for (k = 0; k < 3; k++)
        begin
            @(posedge i_clk);
            i_cpu_req.enter_sleep <= 1'h1;
            i_cfg.wdog_always_on <= (k == 2);
            @(posedge i_clk);
            i_cpu_req.enter_sleep <= 1'h0;
            repeat (2) @(negedge i_clk);
            chk("sleep osc", 8'h0, o_osc_run);
            chk("sleep cpu", 8'h0, o_cpu_clk_en);
            wake_cnt = 0;
            @(posedge i_clk);
            i_irq_pending <= (k == 0);
            i_ext_reset_n <= (k != 1);
            repeat (10) @(posedge i_clk);
            i_irq_pending <= 1'h0;
            i_ext_reset_n <= 1'h1;
            wait_hold(n);
            chk_rng("wake hold", OST_CYC - 16, OST_CYC + 40, n);
            chk("wdog wake", (k == 2), wake_cnt);
            chk("wake cpu", 8'h1, o_cpu_clk_en);
        end
        @(posedge i_clk);
        i_cfg.wdog_always_on <= 1'h0;
        $display("test sleep done");
        give_verdict();
    end
endmodule // reset_and_power_mode_control_tb

// *** src/reset_and_power_mode_control.sv ***
// reset hold, watchdog and sleep/idle sequencing for a microcontroller
`timescale 1ns/1ns
// Summary of operation
// RL1: watchdog forced on by config, else software
// RL2: watchdog counts its own rc oscillator ticks
// RL3: reset held until start-up timer expires
// RL4: power-up hold only after power-on event
// RL5: sleep exits on reset, watchdog or interrupt
// RL6: idle gates cpu clock, sources keep running
// RL7: start-up timer counts 1024 oscillator periods
// RL8: clock source from config at por/bor
// RL9: release reset after both holds expire
module reset_and_power_mode_control
#(
    parameter int PWRUP_COUNT = rst_pwr_pkg::PWRUP_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_power_on,
    input wire logic i_brown_out_reset,
    input wire logic i_ext_reset_n,
    input wire logic i_osc_tick,
    input wire logic i_rc_tick,
    input wire logic i_irq_pending,
    input wire rst_pwr_pkg::cfg_t i_cfg,
    input wire rst_pwr_pkg::cpu_req_t i_cpu_req,
    output logic o_core_reset,
    output logic o_cpu_clk_en,
    output logic o_osc_run,
    output logic o_periph_clk_en,
    output logic o_watchdog_timer_on,
    output logic o_watchdog_timer_wake,
    output logic [2:0] o_clk_source
);

    // three-stage pin synchronisers: por, bor, ext reset, osc tick, rc tick
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [4:0] pin_s3_q;
    logic [4:0] pin_raw;
    logic [4:0] pin_lvl_q;
    logic [4:0] pin_lvl_d;
    logic [4:0] pin_prev_q;
    // sequencer state and counters
    rst_pwr_pkg::seq_state_t state_q;
    rst_pwr_pkg::seq_state_t state_d;
    logic [rst_pwr_pkg::OST_WIDTH-1:0] ost_cnt_q;
    logic [rst_pwr_pkg::OST_WIDTH-1:0] ost_cnt_d;
    logic [rst_pwr_pkg::PWRUP_WIDTH-1:0] pwr_cnt_q;
    logic [rst_pwr_pkg::PWRUP_WIDTH-1:0] pwr_cnt_d;
    logic [rst_pwr_pkg::WDOG_WIDTH-1:0] wdg_cnt_q;
    logic [rst_pwr_pkg::WDOG_WIDTH-1:0] wdg_cnt_d;
    logic [2:0] clk_src_q;
    logic [2:0] clk_src_d;
    logic wdg_wake_q;
    logic wdg_wake_d;
    // decoded conditions
    logic por_evt;
    logic bor_evt;
    logic ext_rst;
    logic osc_edge;
    logic rc_edge;
    logic wdg_on;
    logic wdg_expire;
    // assertions sample on the system clock, quiet while in reset
    default clocking cb_sys @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    assign pin_raw = {i_rc_tick, i_osc_tick, ~i_ext_reset_n,
                      i_brown_out_reset, i_power_on};

    // synchroniser chain per pin, with agreement filter on stages 2 and 3
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            always_comb
            begin
                pin_lvl_d[gi] = pin_lvl_q[gi];
                if (pin_s2_q[gi] == pin_s3_q[gi])
                    pin_lvl_d[gi] = pin_s3_q[gi];
            end
            always_ff @(posedge i_clk)
            begin
                if (i_srst)
                begin
                    pin_s1_q[gi] <= 1'b0;
                    pin_s2_q[gi] <= 1'b0;
                    pin_s3_q[gi] <= 1'b0;
                    pin_lvl_q[gi] <= 1'b0;
                    pin_prev_q[gi] <= 1'b0;
                end
                else
                begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                    pin_s3_q[gi] <= pin_s2_q[gi];
                    pin_lvl_q[gi] <= pin_lvl_d[gi];
                    pin_prev_q[gi] <= pin_lvl_q[gi];
                end
            end
        end
    endgenerate

    // rising edges of filtered levels, ext reset taken as the filtered level
    assign por_evt = pin_lvl_q[0] & ~pin_prev_q[0];
    assign bor_evt = pin_lvl_q[1] & ~pin_prev_q[1];
    assign ext_rst = pin_lvl_q[2];
    assign osc_edge = pin_lvl_q[3] & ~pin_prev_q[3];
    assign rc_edge = pin_lvl_q[4] & ~pin_prev_q[4];

    // RL1: config forces watchdog, else software bit
    assign wdg_on = i_cfg.wdog_always_on | i_cpu_req.wdog_sw_enable;
    // RL2: expiry counted on rc ticks only
    assign wdg_expire = wdg_on & rc_edge
                        & (wdg_cnt_q == rst_pwr_pkg::WDOG_LAST);

    // next-state logic for sequencer, timers and clock selection
    always_comb
    begin
        state_d = state_q;
        ost_cnt_d = ost_cnt_q;
        pwr_cnt_d = pwr_cnt_q;
        wdg_cnt_d = wdg_cnt_q;
        clk_src_d = clk_src_q;
        wdg_wake_d = 1'b0;
        // watchdog counts in every state while enabled
        if (!wdg_on)
            wdg_cnt_d = '0;
        else if (rc_edge)
            wdg_cnt_d = wdg_cnt_q + 1'b1;
        if (por_evt || bor_evt)
        begin
            // RL8: clock source reloaded from configuration
            clk_src_d = i_cfg.clk_source;
            ost_cnt_d = '0;
            // RL4: power-up hold only on power-on
            pwr_cnt_d = por_evt
                ? rst_pwr_pkg::PWRUP_WIDTH'(PWRUP_COUNT) : '0;
            state_d = por_evt ? rst_pwr_pkg::ST_PWRUP : rst_pwr_pkg::ST_OST;
        end
        else
        begin
            case (state_q)
                rst_pwr_pkg::ST_PWRUP:
                begin
                    // power-up hold counts down on system clock
                    if (pwr_cnt_q != '0)
                        pwr_cnt_d = pwr_cnt_q - 1'b1;
                    // RL9: start-up timer runs in parallel
                    if (osc_edge && ost_cnt_q != rst_pwr_pkg::OST_LAST)
                        ost_cnt_d = ost_cnt_q + 1'b1;
                    // RL9: saturates one short, so the last tick waits in ST_OST
                    if (pwr_cnt_q == '0)
                        state_d = rst_pwr_pkg::ST_OST;
                end
                rst_pwr_pkg::ST_OST:
                begin
                    // RL7: count 1024 oscillator periods
                    if (osc_edge)
                    begin
                        ost_cnt_d = ost_cnt_q + 1'b1;
                        // RL3: release only at terminal count
                        if (ost_cnt_q == rst_pwr_pkg::OST_LAST)
                            state_d = rst_pwr_pkg::ST_RUN;
                    end
                end
                rst_pwr_pkg::ST_RUN:
                begin
                    // software clock switch
                    if (i_cpu_req.clk_switch)
                        clk_src_d = i_cpu_req.clk_target;
                    if (ext_rst || wdg_expire)
                    begin
                        ost_cnt_d = '0;
                        wdg_cnt_d = '0;
                        state_d = rst_pwr_pkg::ST_OST;
                    end
                    else if (i_cpu_req.enter_sleep)
                        state_d = rst_pwr_pkg::ST_SLEEP;
                    else if (i_cpu_req.enter_idle)
                        state_d = rst_pwr_pkg::ST_IDLE;
                end
                rst_pwr_pkg::ST_IDLE:
                begin
                    // RL6: idle leaves sources running
                    if (ext_rst || wdg_expire)
                    begin
                        ost_cnt_d = '0;
                        wdg_cnt_d = '0;
                        state_d = rst_pwr_pkg::ST_OST;
                    end
                    else if (i_irq_pending)
                        state_d = rst_pwr_pkg::ST_RUN;
                end
                rst_pwr_pkg::ST_SLEEP:
                begin
                    // RL5: wake via reset, watchdog or interrupt
                    if (ext_rst || wdg_expire || i_irq_pending)
                    begin
                        wdg_wake_d = wdg_expire & ~ext_rst;
                        wdg_cnt_d = '0;
                        ost_cnt_d = '0;
                        // oscillator restarts, so start-up hold reapplies
                        state_d = rst_pwr_pkg::ST_OST;
                    end
                end
                default:
                    state_d = rst_pwr_pkg::ST_PWRUP;
            endcase
        end
    end

    // register sequencer state
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_q <= rst_pwr_pkg::ST_PWRUP;
            ost_cnt_q <= '0;
            pwr_cnt_q <= '0;
            wdg_cnt_q <= '0;
            clk_src_q <= '0;
            wdg_wake_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ost_cnt_q <= ost_cnt_d;
            pwr_cnt_q <= pwr_cnt_d;
            wdg_cnt_q <= wdg_cnt_d;
            clk_src_q <= clk_src_d;
            wdg_wake_q <= wdg_wake_d;
        end
    end

    // outputs decoded from registered state, except watchdog on taken straight from wdg_on
    assign o_core_reset = (state_q == rst_pwr_pkg::ST_PWRUP)
                          | (state_q == rst_pwr_pkg::ST_OST);
    assign o_cpu_clk_en = (state_q == rst_pwr_pkg::ST_RUN);
    assign o_osc_run = (state_q != rst_pwr_pkg::ST_SLEEP);
    assign o_periph_clk_en = (state_q == rst_pwr_pkg::ST_RUN)
                             | (state_q == rst_pwr_pkg::ST_IDLE);
    assign o_watchdog_timer_on = wdg_on;
    assign o_watchdog_timer_wake = wdg_wake_q;
    assign o_clk_source = clk_src_q;

    // release marks the end of every reset hold
    sequence seq_release;
        $fell(o_core_reset);
    endsequence
    // RL3: release only on the last start-up tick
    AST_OST_HOLD: assert property ( // RL3
        seq_release |-> $past(ost_cnt_q) == rst_pwr_pkg::OST_LAST
        && $past(osc_edge))
        else $error("left start-up hold early");
    // RL9: power-up hold done before release
    AST_BOTH_HOLDS: assert property ( // RL9
        seq_release |-> $past(pwr_cnt_q) == '0
        && $past(state_q) == rst_pwr_pkg::ST_OST)
        else $error("released during power-up hold");
    // RL4: brown-out skips power-up hold
    AST_BOR_NO_PWRUP: assert property ( // RL4
        (bor_evt && !por_evt) |=> state_q == rst_pwr_pkg::ST_OST)
        else $error("power-up hold on non-power-on reset");
    // RL6: idle keeps peripherals clocked, cpu stopped
    AST_IDLE_CLK: assert property ( // RL6
        state_q == rst_pwr_pkg::ST_IDLE
        |-> !o_cpu_clk_en && o_periph_clk_en && o_osc_run)
        else $error("idle clock gating wrong");
    // RL5: interrupt ends sleep next cycle
    AST_SLEEP_WAKE: assert property ( // RL5
        (state_q == rst_pwr_pkg::ST_SLEEP && i_irq_pending && !por_evt
         && !bor_evt) |=> state_q == rst_pwr_pkg::ST_OST)
        else $error("sleep not exited on interrupt");
    // RL1: configuration forces watchdog on
    AST_WDOG_FORCED: assert property ( // RL1
        i_cfg.wdog_always_on |-> o_watchdog_timer_on)
        else $error("watchdog not forced on");
    // RL2: watchdog count moves only on rc ticks
    AST_WDOG_RC: assert property ( // RL2
        (wdg_on && !rc_edge && $stable(wdg_on) && state_q == state_d)
        |=> $stable(wdg_cnt_q))
        else $error("watchdog counted without rc tick");
    // RL8: power-on loads configured clock source
    AST_CLK_CFG: assert property ( // RL8
        por_evt |=> o_clk_source == $past(i_cfg.clk_source))
        else $error("clock source not from configuration");
    // RL7: start-up count advances by one per oscillator tick
    AST_OST_STEP: assert property ( // RL7
        (state_q == rst_pwr_pkg::ST_OST && osc_edge && !por_evt && !bor_evt)
        |=> ost_cnt_q == $past(ost_cnt_q) + 1'b1)
        else $error("start-up counter did not step");

endmodule // reset_and_power_mode_control

// *** src/rst_pwr_pkg.sv ***
// shared constants and types for the reset and power-mode sequencer
package rst_pwr_pkg;
    // oscillator start-up counter width and terminal count
    localparam int OST_WIDTH = 10;
    localparam logic [9:0] OST_LAST = 10'h3FF;
    // power-up hold time in microseconds, and its cycle count at 50 MHz
    localparam int PWRUP_HOLD_US = 64;
    localparam int CLK_MHZ = 50;
    localparam int PWRUP_CYCLES = PWRUP_HOLD_US * CLK_MHZ;
    localparam int PWRUP_WIDTH = 13;
    // watchdog counter width, counted in rc-oscillator ticks
    localparam int WDOG_WIDTH = 8;
    localparam logic [7:0] WDOG_LAST = 8'hFF;
    // clock source selection width
    localparam int CLKSEL_WIDTH = 3;

    // sequencer states
    typedef enum logic [2:0] {
        ST_PWRUP = 3'h0,
        ST_OST = 3'h1,
        ST_RUN = 3'h2,
        ST_IDLE = 3'h3,
        ST_SLEEP = 3'h4
    } seq_state_t;

    // configuration settings: clock source sampled at power-on or brown-out, watchdog bit read live
    typedef struct packed {
        logic wdog_always_on;
        logic [2:0] clk_source;
    } cfg_t;

    // power-mode requests from the cpu
    typedef struct packed {
        logic wdog_sw_enable;
        logic enter_sleep;
        logic enter_idle;
        logic clk_switch;
        logic [2:0] clk_target;
    } cpu_req_t;
endpackage
